//--- hw/xoxd_pkg.sv
package xoxd_pkg;
  // widths
  localparam int ADDR_W = 12;
  localparam int PC_W   = 21;

  // opcode prefixes and positions
  localparam logic [5:0]  OP_XOR_FILE   = 6'h06;   // 0001 10da
  localparam logic [7:0]  OP_ADD_PTR    = 8'hE8;
  localparam logic [7:0]  OP_SUB_PTR    = 8'hE9;
  localparam logic [7:0]  OP_PUSH_LIT   = 8'hEA;
  localparam logic [7:0]  OP_MOVE_OFS   = 8'hEB;
  localparam logic [15:0] OP_CALL_W     = 16'h0014;
  localparam logic [3:0]  OP_SECOND_WD  = 4'hF;
  localparam logic [1:0]  SEL_FRAME     = 2'h3;
  localparam int          BIT_DEST      = 9;
  localparam int          BIT_ACCESS    = 8;
  localparam int          BIT_MOVE_KIND = 7;

  // address map
  localparam logic [7:0]        INDEXED_MAX  = 8'h5F;
  localparam logic [3:0]        ACCESS_HIGH  = 4'hF;
  localparam logic [3:0]        ACCESS_LOW   = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_RESET    = 12'h000;
  localparam logic [7:0]        WORKING_REGISTER_RESET   = 8'h00;
  localparam logic [7:0]        PUSH_STEP    = 8'h01;

  typedef enum logic [1:0] {
    XOXD_EXEC,
    XOXD_DEAD,
    XOXD_MOVE2
  } xoxd_state_e;
endpackage

//--- hw/xoxd_ptr_alu.sv
`timescale 1ns/10ps
module xoxd_ptr_alu #(
  parameter int W = 12
) (
  // operands
  input  wire logic [W-1:0] ptr,
  input  wire logic [7:0]   operand,
  input  wire logic         subtract,
  // result
  output logic      [W-1:0] result
);
  // operand is eight bits wide, a narrower pointer cannot hold it
  if (W < 8) begin : g_width_check
    $error("pointer width below operand width");
  end

  always_comb begin
    if (subtract) begin
      result = ptr - W'(operand);
    end else begin
      result = ptr + W'(operand);
    end
  end
endmodule

//--- hw/xoxd_core.sv
`timescale 1ns/10ps
// Function
// - opcode 0001 10da ffff ffff is exclusive-OR of working register with file
// - destination bit 0 writes working register, 1 writes the file register
// - exclusive-OR updates only negative and zero flags
// - access bit 0 uses access bank, 1 uses bank select register
// - access 0, extension on, address up to 95 uses indexed literal offset
// - extension active when unprogrammed; configuration bit enables or disables it
// - extension adds eight literal pointer instructions to the standard set
// - add/subtract 6-bit literal to selected pointer, one cycle, flags unchanged
// - select field 11 works on frame pointer then returns, two cycles
// - opcode 0000 0000 0001 0100 calls through working register, two cycles
// - two-word moves: offset source, absolute or offset destination, two cycles
// - push literal at frame pointer then decrement pointer, one cycle
// - add-and-return loads program counter from return stack top, then no-op
module xoxd_core (
  // clock and reset
  input  wire logic                        REF_CLK,
  input  wire logic                        RST_B,
  // configuration fuse, high enables the extension
  input  wire logic                        EXTENSION_ENABLE_FUSE,
  // instruction stream
  input  wire logic [15:0]                 INSTR_WORD,
  input  wire logic                        INSTR_VALID,
  output logic                             INSTR_READY,
  output logic                             INSTR_UNHANDLED,
  // core context
  input  wire logic [3:0]                  BANK_SELECT_REGISTER,
  input  wire logic [xoxd_pkg::PC_W-1:0]   RETURN_STACK_TOP,
  input  wire logic [12:0]                 PC_LATCH,
  // data memory
  output logic [xoxd_pkg::ADDR_W-1:0]      DMEM_RADDR,
  input  wire logic [7:0]                  DMEM_RDATA,
  output logic [xoxd_pkg::ADDR_W-1:0]      DMEM_WADDR,
  output logic [7:0]                       DMEM_WDATA,
  output logic                             DMEM_WE,
  // program flow
  output logic                             PC_LOAD,
  output logic                             RET_PUSH,
  output logic                             RET_POP,
  output logic [xoxd_pkg::PC_W-1:0]        PC_TARGET,
  // architectural state
  output logic [7:0]                       WORKING_REGISTER,
  output logic [xoxd_pkg::ADDR_W-1:0]      FILE_SELECT_POINTER0,
  output logic [xoxd_pkg::ADDR_W-1:0]      FILE_SELECT_POINTER1,
  output logic [xoxd_pkg::ADDR_W-1:0]      STACK_FRAME_POINTER,
  output logic                             FLAG_NEGATIVE,
  output logic                             FLAG_ZERO,
  output logic                             FLAGS_UPDATED
);
  localparam int AW = xoxd_pkg::ADDR_W;

  // fuse synchroniser
  logic fuse_meta_reg;
  logic fuse_sync_reg;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fuse_meta_reg <= 1'b1;
      fuse_sync_reg <= 1'b1;
    end else begin
      fuse_meta_reg <= EXTENSION_ENABLE_FUSE;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end
  logic ext_on;
  assign ext_on = fuse_sync_reg;

  // state
  xoxd_pkg::xoxd_state_e state_reg, state_next;
  logic [7:0]    working_register_reg, working_register_next;
  logic [AW-1:0] ptr_reg [3];
  logic [AW-1:0] ptr_next [3];
  logic          neg_reg, neg_next, zero_reg, zero_next, upd_reg, upd_next;
  logic [7:0]    hold_reg, hold_next;
  logic          abs_dest_reg, abs_dest_next;
  logic [AW-1:0] waddr_reg, waddr_next;
  logic [7:0]    wdata_reg, wdata_next;
  logic          we_reg, we_next;
  logic          pcl_reg, pcl_next, push_reg, push_next, pop_reg, pop_next, unh_reg, unh_next;
  logic [xoxd_pkg::PC_W-1:0] pct_reg, pct_next;

  // decode
  logic       take;
  logic [7:0] op_hi;
  logic [7:0] f_lit;
  logic [1:0] psel;
  logic       is_xor, is_addp, is_subp, is_push, is_move, is_call_via_working_reg;
  assign take   = INSTR_VALID && INSTR_READY;
  assign op_hi  = INSTR_WORD[15:8];
  assign f_lit  = INSTR_WORD[7:0];
  assign psel   = INSTR_WORD[7:6];
  assign is_xor = (INSTR_WORD[15:10] == xoxd_pkg::OP_XOR_FILE);
  // extended opcodes are only honoured with the fuse set
  assign is_addp  = ext_on && (op_hi == xoxd_pkg::OP_ADD_PTR);
  assign is_subp  = ext_on && (op_hi == xoxd_pkg::OP_SUB_PTR);
  assign is_push  = ext_on && (op_hi == xoxd_pkg::OP_PUSH_LIT);
  assign is_move  = ext_on && (op_hi == xoxd_pkg::OP_MOVE_OFS);
  assign is_call_via_working_reg = ext_on && (INSTR_WORD == xoxd_pkg::OP_CALL_W);

  // offset adder on the frame pointer
  logic [AW-1:0] frame_ofs;
  logic [7:0]    ofs_in;
  always_comb begin
    if (state_reg == xoxd_pkg::XOXD_MOVE2 || is_move) begin
      ofs_in = {1'b0, INSTR_WORD[6:0]};
    end else begin
      ofs_in = f_lit;
    end
  end
  xoxd_ptr_alu #(.W(AW)) u_ofs (
    .ptr      (ptr_reg[2]),
    .operand  (ofs_in),
    .subtract (1'b0),
    .result   (frame_ofs)
  );

  // pointer update adder
  logic [1:0]    upd_sel;
  logic [7:0]    upd_opnd;
  logic          upd_sub;
  logic [AW-1:0] upd_res;
  always_comb begin
    if (is_push) begin
      upd_sel  = 2'h2;
      upd_opnd = xoxd_pkg::PUSH_STEP;
      upd_sub  = 1'b1;
    end else begin
      upd_sel  = (psel == xoxd_pkg::SEL_FRAME) ? 2'h2 : psel;
      upd_opnd = {2'h0, INSTR_WORD[5:0]};
      upd_sub  = is_subp;
    end
  end
  xoxd_ptr_alu #(.W(AW)) u_upd (
    .ptr      (ptr_reg[upd_sel]),
    .operand  (upd_opnd),
    .subtract (upd_sub),
    .result   (upd_res)
  );

  // file address of a byte-oriented instruction
  logic [AW-1:0] file_addr;
  always_comb begin
    if (INSTR_WORD[xoxd_pkg::BIT_ACCESS]) begin
      file_addr = {BANK_SELECT_REGISTER, f_lit};
    end else if (ext_on && f_lit <= xoxd_pkg::INDEXED_MAX) begin
      file_addr = frame_ofs;
    end else if (f_lit <= xoxd_pkg::INDEXED_MAX) begin
      file_addr = {xoxd_pkg::ACCESS_LOW, f_lit};
    end else begin
      file_addr = {xoxd_pkg::ACCESS_HIGH, f_lit};
    end
  end

  always_comb begin
    if (is_move) begin
      DMEM_RADDR = frame_ofs;
    end else begin
      DMEM_RADDR = file_addr;
    end
  end

  logic [7:0] xor_res;
  assign xor_res     = working_register_reg ^ DMEM_RDATA;
  assign INSTR_READY = (state_reg != xoxd_pkg::XOXD_DEAD);

  always_comb begin
    state_next    = state_reg;
    working_register_next     = working_register_reg;
    ptr_next      = ptr_reg;
    neg_next      = neg_reg;
    zero_next     = zero_reg;
    upd_next      = 1'b0;
    hold_next     = hold_reg;
    abs_dest_next = abs_dest_reg;
    waddr_next    = waddr_reg;
    wdata_next    = wdata_reg;
    we_next       = 1'b0;
    pcl_next      = 1'b0;
    push_next     = 1'b0;
    pop_next      = 1'b0;
    unh_next      = 1'b0;
    pct_next      = pct_reg;
    unique case (state_reg)
      xoxd_pkg::XOXD_DEAD: begin
        state_next = xoxd_pkg::XOXD_EXEC;
      end
      xoxd_pkg::XOXD_MOVE2: begin
        if (take) begin
          state_next = xoxd_pkg::XOXD_EXEC;
          if (INSTR_WORD[15:12] == xoxd_pkg::OP_SECOND_WD) begin
            we_next    = 1'b1;
            wdata_next = hold_reg;
            waddr_next = abs_dest_reg ? INSTR_WORD[AW-1:0] : frame_ofs;
          end else begin
            unh_next = 1'b1;
          end
        end
      end
      xoxd_pkg::XOXD_EXEC: begin
        if (take) begin
          if (is_xor) begin
            neg_next  = xor_res[7];
            zero_next = (xor_res == 8'h00);
            upd_next  = 1'b1;
            if (INSTR_WORD[xoxd_pkg::BIT_DEST]) begin
              we_next    = 1'b1;
              waddr_next = file_addr;
              wdata_next = xor_res;
            end else begin
              working_register_next = xor_res;
            end
          end else if (is_addp || is_subp) begin
            ptr_next[upd_sel] = upd_res;
            if (psel == xoxd_pkg::SEL_FRAME) begin
              pcl_next   = 1'b1;
              pop_next   = 1'b1;
              pct_next   = RETURN_STACK_TOP;
              state_next = xoxd_pkg::XOXD_DEAD;
            end
          end else if (is_push) begin
            we_next     = 1'b1;
            waddr_next  = ptr_reg[2];
            wdata_next  = f_lit;
            ptr_next[2] = upd_res;
          end else if (is_call_via_working_reg) begin
            pcl_next   = 1'b1;
            push_next  = 1'b1;
            pct_next   = {PC_LATCH, working_register_reg};
            state_next = xoxd_pkg::XOXD_DEAD;
          end else if (is_move) begin
            hold_next     = DMEM_RDATA;
            abs_dest_next = !INSTR_WORD[xoxd_pkg::BIT_MOVE_KIND];
            state_next    = xoxd_pkg::XOXD_MOVE2;
          end else begin
            unh_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = xoxd_pkg::XOXD_EXEC;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg    <= xoxd_pkg::XOXD_EXEC;
      working_register_reg     <= xoxd_pkg::WORKING_REGISTER_RESET;
      ptr_reg      <= '{default: xoxd_pkg::PTR_RESET};
      neg_reg      <= 1'b0;
      zero_reg     <= 1'b0;
      upd_reg      <= 1'b0;
      hold_reg     <= 8'h00;
      abs_dest_reg <= 1'b0;
      waddr_reg    <= xoxd_pkg::PTR_RESET;
      wdata_reg    <= 8'h00;
      we_reg       <= 1'b0;
      pcl_reg      <= 1'b0;
      push_reg     <= 1'b0;
      pop_reg      <= 1'b0;
      unh_reg      <= 1'b0;
      pct_reg      <= '0;
    end else begin
      state_reg    <= state_next;
      working_register_reg     <= working_register_next;
      ptr_reg      <= ptr_next;
      neg_reg      <= neg_next;
      zero_reg     <= zero_next;
      upd_reg      <= upd_next;
      hold_reg     <= hold_next;
      abs_dest_reg <= abs_dest_next;
      waddr_reg    <= waddr_next;
      wdata_reg    <= wdata_next;
      we_reg       <= we_next;
      pcl_reg      <= pcl_next;
      push_reg     <= push_next;
      pop_reg      <= pop_next;
      unh_reg      <= unh_next;
      pct_reg      <= pct_next;
    end
  end

  assign WORKING_REGISTER     = working_register_reg;
  assign FILE_SELECT_POINTER0 = ptr_reg[0];
  assign FILE_SELECT_POINTER1 = ptr_reg[1];
  assign STACK_FRAME_POINTER  = ptr_reg[2];
  assign FLAG_NEGATIVE        = neg_reg;
  assign FLAG_ZERO            = zero_reg;
  assign FLAGS_UPDATED        = upd_reg;
  assign DMEM_WADDR           = waddr_reg;
  assign DMEM_WDATA           = wdata_reg;
  assign DMEM_WE              = we_reg;
  assign PC_LOAD              = pcl_reg;
  assign RET_PUSH             = push_reg;
  assign RET_POP              = pop_reg;
  assign PC_TARGET            = pct_reg;
  assign INSTR_UNHANDLED      = unh_reg;
endmodule

//--- test/xoxd_core_properties.sv
`timescale 1ns/10ps
module xoxd_core_chk (
  // clock, reset, fuse
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        EXTENSION_ENABLE_FUSE,
  // instruction and context
  input wire logic [15:0] INSTR_WORD,
  input wire logic        INSTR_VALID,
  input wire logic        INSTR_READY,
  input wire logic        INSTR_UNHANDLED,
  input wire logic [3:0]  BANK_SELECT_REGISTER,
  input wire logic [20:0] RETURN_STACK_TOP,
  input wire logic [12:0] PC_LATCH,
  // memory and flow
  input wire logic [11:0] DMEM_RADDR,
  input wire logic [7:0]  DMEM_RDATA,
  input wire logic [11:0] DMEM_WADDR,
  input wire logic [7:0]  DMEM_WDATA,
  input wire logic        DMEM_WE,
  input wire logic        PC_LOAD,
  input wire logic        RET_PUSH,
  input wire logic        RET_POP,
  input wire logic [20:0] PC_TARGET,
  // state
  input wire logic [7:0]  WORKING_REGISTER,
  input wire logic [11:0] STACK_FRAME_POINTER,
  input wire logic        FLAG_NEGATIVE,
  input wire logic        FLAG_ZERO,
  input wire logic        FLAGS_UPDATED
);
  logic [2:0] fz_reg;
  logic [2:0] fz_next;
  logic       tk;
  logic       xr;
  logic       on;
  logic       off;
  // fuse settled for three edges, beyond the sync delay
  always_comb fz_next = {fz_reg[1:0], EXTENSION_ENABLE_FUSE};
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) fz_reg <= 3'h7;
    else fz_reg <= fz_next;
  end
  assign tk = INSTR_VALID && INSTR_READY;
  assign xr = tk && INSTR_WORD[15:10] == 6'h06;
  assign on = EXTENSION_ENABLE_FUSE && fz_reg == 3'h7;
  assign off = !EXTENSION_ENABLE_FUSE && fz_reg == 3'h0;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_ret;
    PC_LOAD && RET_POP && !INSTR_READY ##1 INSTR_READY;
  endsequence
  sequence s_call;
    PC_LOAD && RET_PUSH && !INSTR_READY ##1 INSTR_READY;
  endsequence
  a_xor_file_wr: assert property (xr && INSTR_WORD[9] |=> DMEM_WE &&
    DMEM_WDATA == ($past(WORKING_REGISTER) ^ $past(DMEM_RDATA)))
    else $error("xor file write wrong");
  a_xor_w_wr: assert property (xr && !INSTR_WORD[9] |=> !DMEM_WE &&
    WORKING_REGISTER == ($past(WORKING_REGISTER) ^ $past(DMEM_RDATA)))
    else $error("xor w write wrong");
  a_xor_flags: assert property (xr |=> FLAGS_UPDATED &&
    FLAG_ZERO == (($past(WORKING_REGISTER) ^ $past(DMEM_RDATA)) == 8'h00) &&
    FLAG_NEGATIVE == ($past(WORKING_REGISTER[7]) ^ $past(DMEM_RDATA[7])))
    else $error("xor flags wrong");
  a_bank_addr: assert property (xr && INSTR_WORD[8] |->
    DMEM_RADDR == {BANK_SELECT_REGISTER, INSTR_WORD[7:0]}) else $error("bank address wrong");
  a_index_addr: assert property (xr && on && !INSTR_WORD[8] && INSTR_WORD[7:0] <= 8'h5F |->
    DMEM_RADDR == STACK_FRAME_POINTER + INSTR_WORD[7:0]) else $error("indexed address wrong");
  a_access_std: assert property (xr && off && !INSTR_WORD[8] |-> DMEM_RADDR ==
    {(INSTR_WORD[7:0] > 8'h5F) ? 4'hF : 4'h0, INSTR_WORD[7:0]}) else $error("access wrong");
  a_ret_form: assert property (tk && on && INSTR_WORD[15:9] == 7'h74 &&
    INSTR_WORD[7:6] == 2'h3 |=> PC_TARGET == $past(RETURN_STACK_TOP) ##0 s_ret)
    else $error("return form wrong");
  a_call_target: assert property (tk && on && INSTR_WORD == 16'h0014 |=>
    PC_TARGET == {$past(PC_LATCH), $past(WORKING_REGISTER)} ##0 s_call)
    else $error("call wrong");
  a_push_frame: assert property (tk && on && INSTR_WORD[15:8] == 8'hEA |=> DMEM_WE &&
    DMEM_WADDR == $past(STACK_FRAME_POINTER) && DMEM_WDATA == $past(INSTR_WORD[7:0]) &&
    STACK_FRAME_POINTER == $past(STACK_FRAME_POINTER) - 12'h001) else $error("push wrong");
  a_ext_off: assert property (tk && off && INSTR_WORD[15:11] == 5'h1D |=>
    INSTR_UNHANDLED && !DMEM_WE && !PC_LOAD) else $error("extended op ran while off");
endmodule
bind xoxd_core xoxd_core_chk chk_u (
  .REF_CLK              (REF_CLK),
  .RST_B                (RST_B),
  .EXTENSION_ENABLE_FUSE(EXTENSION_ENABLE_FUSE),
  .INSTR_WORD           (INSTR_WORD),
  .INSTR_VALID          (INSTR_VALID),
  .INSTR_READY          (INSTR_READY),
  .INSTR_UNHANDLED      (INSTR_UNHANDLED),
  .BANK_SELECT_REGISTER (BANK_SELECT_REGISTER),
  .RETURN_STACK_TOP     (RETURN_STACK_TOP),
  .PC_LATCH             (PC_LATCH),
  .DMEM_RADDR           (DMEM_RADDR),
  .DMEM_RDATA           (DMEM_RDATA),
  .DMEM_WADDR           (DMEM_WADDR),
  .DMEM_WDATA           (DMEM_WDATA),
  .DMEM_WE              (DMEM_WE),
  .PC_LOAD              (PC_LOAD),
  .RET_PUSH             (RET_PUSH),
  .RET_POP              (RET_POP),
  .PC_TARGET            (PC_TARGET),
  .WORKING_REGISTER     (WORKING_REGISTER),
  .STACK_FRAME_POINTER  (STACK_FRAME_POINTER),
  .FLAG_NEGATIVE        (FLAG_NEGATIVE),
  .FLAG_ZERO            (FLAG_ZERO),
  .FLAGS_UPDATED        (FLAGS_UPDATED)
);

//--- test/xoxd_core_tb_top.sv
`timescale 1ns/10ps
module xoxd_core_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic fuse = 1'b1;
  logic valid = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [7:0] rdata = 8'h00;
  logic ready, unh, we, pcld, push, pop, fn, fz, fu;
  logic [11:0] raddr, waddr, p0, p1, sfp, ra;
  logic [7:0] wdata, w;
  logic [20:0] tgt;
  logic [3:0]  bank_select_register = 4'h5;
  logic [20:0] return_stack_top = 21'h1_ABCD;
  logic [12:0] pcl = 13'h1234;
  int n_mismatch = 0;
  int checks_done = 0;

  always #2 ref_clk = ~ref_clk;

  xoxd_core dut_u (
    .REF_CLK(ref_clk), .RST_B(rst_b), .EXTENSION_ENABLE_FUSE(fuse),
    .INSTR_WORD(word), .INSTR_VALID(valid), .INSTR_READY(ready),
    .INSTR_UNHANDLED(unh), .BANK_SELECT_REGISTER(bank_select_register),
    .RETURN_STACK_TOP(return_stack_top), .PC_LATCH(pcl),
    .DMEM_RADDR(raddr), .DMEM_RDATA(rdata), .DMEM_WADDR(waddr),
    .DMEM_WDATA(wdata), .DMEM_WE(we), .PC_LOAD(pcld), .RET_PUSH(push),
    .RET_POP(pop), .PC_TARGET(tgt), .WORKING_REGISTER(w),
    .FILE_SELECT_POINTER0(p0), .FILE_SELECT_POINTER1(p1),
    .STACK_FRAME_POINTER(sfp), .FLAG_NEGATIVE(fn), .FLAG_ZERO(fz),
    .FLAGS_UPDATED(fu)
  );

  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // one word offered and taken; read address kept from before the take
  task automatic issue(input logic [15:0] iw, input logic [7:0] d);
    @(posedge ref_clk);
    word <= iw;
    rdata <= d;
    valid <= 1'b1;
    #1 ra = raddr;
    @(posedge ref_clk);
    valid <= 1'b0;
    #1;
  endtask

  task automatic t_xor;
    issue(16'h1934, 8'hB5);
    chk("raddr", 12'h534, ra);
    chk("w", 8'hB5, w);
    chk("we", 1'b0, we);
    chk("nz", 2'b10, {fn, fz});
    issue(16'h1A80, 8'hAF);
    chk("raddr", 12'hF80, ra);
    chk("wdata", 8'h1A, wdata);
    chk("we", 1'b1, we);
    chk("w", 8'hB5, w);
    @(posedge ref_clk);
    bank_select_register <= 4'hA;
    issue(16'h1901, 8'hB5);
    chk("raddr", 12'hA01, ra);
    chk("nz", 2'b01, {fn, fz});
    chk("upd", 1'b1, fu);
  endtask

  task automatic t_ptr;
    issue(16'hE823, 8'h00);
    chk("p0", 12'h023, p0);
    chk("upd", 1'b0, fu);
    issue(16'hE941, 8'h00);
    chk("p1", 12'hFFF, p1);
    chk("pcld", 1'b0, pcld);
  endtask

  task automatic t_ret;
    issue(16'hE8C5, 8'h00);
    chk("sfp", 12'h005, sfp);
    chk("tgt", 21'h1_ABCD, tgt);
    chk("pop", 1'b1, pop);
    chk("ready", 1'b0, ready);
    issue(16'hE9C1, 8'h00);
    chk("sfp", 12'h004, sfp);
    chk("pcld", 1'b1, pcld);
  endtask

  task automatic t_mem;
    issue(16'h1810, 8'h3C);
    chk("raddr", 12'h014, ra);
    issue(16'hEA5A, 8'h00);
    chk("waddr", 12'h004, waddr);
    chk("wdata", 8'h5A, wdata);
    chk("sfp", 12'h003, sfp);
    issue(16'hEB03, 8'h77);
    chk("raddr", 12'h006, ra);
    issue(16'hF123, 8'h00);
    chk("waddr", 12'h123, waddr);
    chk("wdata", 8'h77, wdata);
    issue(16'hEB82, 8'h66);
    issue(16'hF005, 8'h00);
    chk("waddr", 12'h008, waddr);
    chk("wdata", 8'h66, wdata);
    issue(16'hEB01, 8'h11);
    issue(16'h0000, 8'h00);
    chk("unh", 1'b1, unh);
    chk("we", 1'b0, we);
  endtask

  task automatic t_call;
    issue(16'h0014, 8'h00);
    chk("tgt", {13'h1234, 8'h3C}, tgt);
    chk("push", 1'b1, push);
    chk("ready", 1'b0, ready);
  endtask

  task automatic t_fuse;
    @(posedge ref_clk);
    fuse <= 1'b0;
    repeat (4) @(posedge ref_clk);
    issue(16'hE823, 8'h00);
    chk("unh", 1'b1, unh);
    chk("p0", 12'h023, p0);
    issue(16'h1810, 8'h00);
    chk("raddr", 12'h010, ra);
    @(posedge ref_clk);
    fuse <= 1'b1;
    repeat (4) @(posedge ref_clk);
    issue(16'hE801, 8'h00);
    chk("p0", 12'h024, p0);
  endtask

  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_xor;
    t_ptr;
    t_ret;
    t_mem;
    t_call;
    t_fuse;
    summarize;
  end

  initial begin
    repeat (1000) @(posedge ref_clk);
    n_mismatch++;
    summarize;
  end
endmodule
